/* File: src/rrf_pkg.sv */
package rrf_pkg;
  // factory parameter set
  localparam logic [15:0] DEF_ADDR   = 16'h0000;
  localparam logic [7:0]  DEF_CHAN   = 8'h12;
  localparam logic [7:0]  DEF_NETWORK_IDENT  = 8'h00;
  // 9600 baud, 8N1, 2.4 kbps air rate
  localparam logic [7:0]  DEF_SERIAL = 8'h62;
  localparam logic [7:0]  DEF_OPTION = 8'h00;
  localparam logic [15:0] DEF_KEY    = 16'h0000;
  // option byte lives at index 06H, repeater enable in bit 5
  localparam logic [7:0]  OPT_REG_IDX = 8'h06;
  localparam int          REP_BIT     = 5;
  localparam logic [7:0]  CHAN_MAX    = 8'h50;
  // mode pin codes
  localparam logic [1:0]  MODE_NORMAL = 2'h0;
  localparam logic [1:0]  MODE_WOR    = 2'h1;
  localparam logic [1:0]  MODE_CFG    = 2'h2;
  localparam logic [1:0]  MODE_SLEEP  = 2'h3;
  // timing
  localparam int CLK_KHZ    = 25000;
  localparam int RELOAD_US  = 20;
  localparam int RELOAD_CYC = (RELOAD_US * CLK_KHZ) / 1000;
  localparam int ECHO_US    = 40;
  localparam int ECHO_CYC   = (ECHO_US * CLK_KHZ) / 1000;
  localparam int CNT_W      = 11;
  // fifo word: {last, network ident, data}
  localparam int FIFO_W     = 17;
  localparam int FIFO_D     = 32;
  localparam int LVL_W      = 6;
  typedef enum logic [1:0] {RX_HEAD, RX_FWD, RX_DELIV, RX_DROP} rrf_rx_e;
endpackage : rrf_pkg

/* File: src/rrf_fifo.sv */
`timescale 1ns/100ps
`default_nettype none
module rrf_fifo #(
  parameter int W = 17,
  parameter int D = 32
) (
  // clock
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   ce,
  // fill side
  input  wire logic                   in_valid,
  input  wire logic [W-1:0]           in_data,
  output logic                        in_ready,
  // drain side
  output logic                        out_valid,
  output logic [W-1:0]                out_data,
  input  wire logic                   out_ready,
  // fill level
  output logic [$clog2(D):0]          level
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0]   next_level;
  logic          push, pop;

  always_comb begin
    in_ready    = level != (AW+1)'(D);
    out_valid   = level != '0;
    out_data    = mem[rd_ptr];
    push        = in_valid && in_ready;
    pop         = out_valid && out_ready;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_level  = level + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= '0;
    end else if (ce) begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      level  <= next_level;
      if (push) begin
        mem[wr_ptr] <= in_data;
      end
    end
  end
endmodule : rrf_fifo
`default_nettype wire

/* File: src/rrf_repeater.sv */
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// [R1] After reset the parameters are address 0000, channel 12, serial 9600 8N1 and air rate 2.4 kbps.
// [R2] Repeating starts only once the repeater option is set and the mode pins are back in normal mode.
// [R3] In repeater mode a packet from either paired network is resent into the other one.
// [R4] In repeater mode the device's own network ident plays no part in forwarding.
// [R5] In repeater mode no serial data is taken or delivered and low-power operation is refused.
// [R6] Leaving sleep mode, or reset, reloads the parameters with the indication output low meanwhile.
// [R7] Forwarding runs both ways between the two paired networks.
// [R8] In repeater mode the address high and low bytes are the two paired network idents.
// [R9] As an endpoint, received data goes to the serial port only if its source address equals ours.
// [R10] Address, channel 0-80, network ident and key must be within range or the write is refused.
// [R11] The host selects configuration mode on the mode pins before parameters are written.
// [R12] Bit 5 of the option byte at 06H enables repeating, and a foreign packet is forwarded once.
// [R13] Each packet is forwarded once with its payload unchanged, and our own echo is not resent.
module rrf_repeater (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  input  wire logic        CE,
  // mode pins, asynchronous
  input  wire logic [1:0]  MODE_SELECT_PINS,
  // parameter write
  input  wire logic        CFG_WE,
  input  wire logic [15:0] CFG_ADDR,
  input  wire logic [7:0]  CFG_NETWORK_IDENT,
  input  wire logic [7:0]  CFG_CHAN,
  input  wire logic [7:0]  CFG_SERIAL,
  input  wire logic [7:0]  CFG_OPTION,
  input  wire logic [15:0] CFG_KEY,
  output logic             CFG_REJECT,
  // active parameters
  output logic [7:0]       ACT_CHAN,
  output logic [7:0]       ACT_SERIAL,
  output logic [15:0]      ACT_KEY,
  // status
  output logic             AUX,
  output logic             REPEATER_ON,
  output logic             LOW_POWER_EN,
  // radio receive stream
  input  wire logic        RX_VALID,
  input  wire logic [7:0]  RX_NETWORK_IDENT,
  input  wire logic [15:0] RX_SRC_ADDR,
  input  wire logic [7:0]  RX_DATA,
  input  wire logic        RX_LAST,
  output logic             RX_READY,
  // radio transmit stream
  output logic             TX_VALID,
  output logic [7:0]       TX_NETWORK_IDENT,
  output logic [7:0]       TX_DATA,
  output logic             TX_LAST,
  input  wire logic        TX_READY,
  // serial user side
  input  wire logic        UART_IN_VALID,
  input  wire logic [7:0]  UART_IN_DATA,
  input  wire logic        UART_IN_LAST,
  output logic             UART_IN_READY,
  output logic             UART_OUT_VALID,
  output logic [7:0]       UART_OUT_DATA
);
  localparam logic [rrf_pkg::CNT_W-1:0] RELOAD_N = rrf_pkg::CNT_W'(rrf_pkg::RELOAD_CYC);
  localparam logic [rrf_pkg::CNT_W-1:0] ECHO_N   = rrf_pkg::CNT_W'(rrf_pkg::ECHO_CYC);
  localparam logic [rrf_pkg::LVL_W-1:0] LVL_HI   = rrf_pkg::LVL_W'(rrf_pkg::FIFO_D - 1);

  function automatic logic [8:0] pair_route(input logic [7:0] n, input logic [15:0] pair);
    if (n == pair[15:8]) return {1'b1, pair[7:0]};
    if (n == pair[7:0]) return {1'b1, pair[15:8]};
    return 9'h000;
  endfunction : pair_route

  // mode and reload
  logic [1:0]               mode_s1, mode_q, mode_prev;
  logic [rrf_pkg::CNT_W-1:0] reload_cnt, next_reload_cnt;
  logic                     reloading, rep_on;
  always_comb begin
    next_reload_cnt = reload_cnt;
    if (mode_q != mode_prev && (mode_prev == rrf_pkg::MODE_SLEEP || mode_prev == rrf_pkg::MODE_CFG)) begin
      next_reload_cnt = RELOAD_N; // [R6]
    end else if (reload_cnt != '0) begin
      next_reload_cnt = reload_cnt - 1'b1;
    end
  end
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      mode_s1    <= rrf_pkg::MODE_NORMAL;
      mode_q     <= rrf_pkg::MODE_NORMAL;
      mode_prev  <= rrf_pkg::MODE_NORMAL;
      reload_cnt <= RELOAD_N; // [R6]
    end else if (CE) begin
      mode_s1    <= MODE_SELECT_PINS;
      mode_q     <= mode_s1;
      mode_prev  <= mode_q;
      reload_cnt <= next_reload_cnt;
    end
  end

  // parameters: saved set written in config mode, active set loaded by reload
  logic [15:0] sv_addr, sv_key, act_addr;
  logic [7:0]  sv_net, sv_chan, sv_ser, sv_opt, act_net, act_opt;
  logic        cfg_ok, load_act;
  always_comb begin
    reloading = reload_cnt != '0;
    load_act  = reload_cnt == rrf_pkg::CNT_W'(1);
    cfg_ok    = CFG_WE && mode_q == rrf_pkg::MODE_CFG && !reloading // [R11]
                && CFG_CHAN <= rrf_pkg::CHAN_MAX; // [R10]
    rep_on    = act_opt[rrf_pkg::REP_BIT] && mode_q == rrf_pkg::MODE_NORMAL && !reloading; // [R2] [R12]
  end
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      {sv_addr, sv_net, sv_chan} <= {rrf_pkg::DEF_ADDR, rrf_pkg::DEF_NETWORK_IDENT, rrf_pkg::DEF_CHAN}; // [R1]
      {sv_ser, sv_opt, sv_key}   <= {rrf_pkg::DEF_SERIAL, rrf_pkg::DEF_OPTION, rrf_pkg::DEF_KEY}; // [R1]
      {act_addr, act_net, ACT_CHAN} <= {rrf_pkg::DEF_ADDR, rrf_pkg::DEF_NETWORK_IDENT, rrf_pkg::DEF_CHAN};
      {ACT_SERIAL, act_opt, ACT_KEY} <= {rrf_pkg::DEF_SERIAL, rrf_pkg::DEF_OPTION, rrf_pkg::DEF_KEY};
      CFG_REJECT <= 1'b0;
    end else if (CE) begin
      CFG_REJECT <= CFG_WE && !cfg_ok; // [R10]
      if (cfg_ok) begin
        {sv_addr, sv_net, sv_chan} <= {CFG_ADDR, CFG_NETWORK_IDENT, CFG_CHAN};
        {sv_ser, sv_opt, sv_key}   <= {CFG_SERIAL, CFG_OPTION, CFG_KEY};
      end
      if (load_act) begin
        {act_addr, act_net, ACT_CHAN}  <= {sv_addr, sv_net, sv_chan}; // [R6]
        {ACT_SERIAL, act_opt, ACT_KEY} <= {sv_ser, sv_opt, sv_key};
      end
    end
  end

  // receive classification
  rrf_pkg::rrf_rx_e          rx_state, next_rx_state, cls;
  logic [7:0]                fwd_net, next_fwd_net, echo_net, next_echo_net, use_net;
  logic [8:0]                route;
  logic [rrf_pkg::CNT_W-1:0] echo_cnt, next_echo_cnt;
  logic                      rx_beat, rx_push, uart_push, echo_hit;
  logic [rrf_pkg::FIFO_W-1:0] f_in, f_out;
  logic                      f_in_rdy, f_out_val, f_out_rdy;
  logic [rrf_pkg::LVL_W-1:0] f_lvl;
  always_comb begin
    rx_beat  = RX_VALID && RX_READY;
    route    = pair_route(RX_NETWORK_IDENT, act_addr); // [R4] [R8]
    echo_hit = echo_cnt != '0 && RX_NETWORK_IDENT == echo_net;
    cls      = rx_state;
    use_net  = fwd_net;
    if (rx_state == rrf_pkg::RX_HEAD) begin
      use_net = route[7:0];
      if (rep_on) begin
        cls = (route[8] && !echo_hit) ? rrf_pkg::RX_FWD : rrf_pkg::RX_DROP; // [R3] [R13]
      end else begin
        cls = (RX_NETWORK_IDENT == act_net && RX_SRC_ADDR == act_addr) ? rrf_pkg::RX_DELIV : rrf_pkg::RX_DROP; // [R9]
      end
    end
    next_rx_state = rx_state;
    next_fwd_net  = fwd_net;
    if (rx_beat) begin
      next_rx_state = RX_LAST ? rrf_pkg::RX_HEAD : cls;
      next_fwd_net  = use_net;
    end
    rx_push   = rx_beat && cls == rrf_pkg::RX_FWD && f_in_rdy; // [R7]
    uart_push = UART_IN_VALID && UART_IN_READY && f_in_rdy;
    f_in      = rx_push ? {RX_LAST, use_net, RX_DATA} : {UART_IN_LAST, act_net, UART_IN_DATA}; // [R13]
    f_out_rdy = !TX_VALID || TX_READY;
    next_echo_cnt = echo_cnt != '0 ? echo_cnt - 1'b1 : echo_cnt;
    next_echo_net = echo_net;
    if (TX_VALID && TX_READY && TX_LAST) begin
      next_echo_cnt = ECHO_N; // [R13]
      next_echo_net = TX_NETWORK_IDENT;
    end
  end

  rrf_fifo #(.W(rrf_pkg::FIFO_W), .D(rrf_pkg::FIFO_D)) u_fifo (
    .clk       (CLK),
    .rst       (SYS_RST),
    .ce        (CE),
    .in_valid  (rx_push || uart_push),
    .in_data   (f_in),
    .in_ready  (f_in_rdy),
    .out_valid (f_out_val),
    .out_data  (f_out),
    .out_ready (f_out_rdy),
    .level     (f_lvl)
  );

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rx_state <= rrf_pkg::RX_HEAD;
      fwd_net  <= 8'h00;
      echo_cnt <= '0;
      echo_net <= 8'h00;
      {RX_READY, UART_IN_READY, UART_OUT_VALID, UART_OUT_DATA} <= 11'h000;
      {TX_VALID, TX_NETWORK_IDENT, TX_DATA, TX_LAST} <= 18'h00000;
      {AUX, REPEATER_ON, LOW_POWER_EN} <= 3'h0; // [R6]
    end else if (CE) begin
      rx_state       <= next_rx_state;
      fwd_net        <= next_fwd_net;
      echo_cnt       <= next_echo_cnt;
      echo_net       <= next_echo_net;
      RX_READY       <= mode_q == rrf_pkg::MODE_NORMAL && !reloading && f_lvl < LVL_HI;
      UART_IN_READY  <= mode_q == rrf_pkg::MODE_NORMAL && !reloading && !rep_on && f_lvl < LVL_HI; // [R5]
      UART_OUT_VALID <= rx_beat && cls == rrf_pkg::RX_DELIV && !rep_on; // [R5]
      UART_OUT_DATA  <= RX_DATA;
      if (f_out_rdy) begin
        TX_VALID <= f_out_val;
        {TX_LAST, TX_NETWORK_IDENT, TX_DATA} <= f_out;
      end
      AUX          <= !reloading && f_lvl == '0 && !TX_VALID; // [R6]
      REPEATER_ON  <= rep_on;
      LOW_POWER_EN <= mode_q == rrf_pkg::MODE_SLEEP && !act_opt[rrf_pkg::REP_BIT]; // [R5]
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST || !CE);

  a_reset_defaults: assert property ($past(SYS_RST) |-> sv_chan == 8'h12 && sv_addr == 16'h0000 && sv_ser == 8'h62) else $error("defaults not restored"); // [R1]
  a_rep_needs_normal: assert property ($rose(rep_on) |-> mode_q == rrf_pkg::MODE_NORMAL // [R2]
    && ($past(reloading) || $past(mode_q) != rrf_pkg::MODE_NORMAL)) else $error("repeater started without a return to normal");
  a_fwd_hi_to_lo: assert property (rep_on && rx_beat && rx_state == rrf_pkg::RX_HEAD && !echo_hit && RX_NETWORK_IDENT == act_addr[15:8] |-> rx_push == f_in_rdy && f_in[15:8] == act_addr[7:0] && f_in[7:0] == RX_DATA) else $error("high ident not forwarded to low"); // [R3]
  a_own_net_ignored: assert property (rep_on && rx_beat && rx_state == rrf_pkg::RX_HEAD && RX_NETWORK_IDENT != act_addr[15:8] && RX_NETWORK_IDENT != act_addr[7:0] |-> !rx_push) else $error("unpaired ident forwarded"); // [R4]
  a_rep_serial_quiet: assert property (rep_on |=> !UART_IN_READY && !UART_OUT_VALID) else $error("serial active in repeater mode"); // [R5]
  a_reload_aux_low: assert property ($rose(reload_cnt == RELOAD_N) |=> !AUX [*8]) else $error("aux high during reload"); // [R6]
  a_fwd_lo_to_hi: assert property (rep_on && rx_beat && rx_state == rrf_pkg::RX_HEAD && !echo_hit && RX_NETWORK_IDENT == act_addr[7:0] && RX_NETWORK_IDENT != act_addr[15:8] |-> f_in[15:8] == act_addr[15:8]) else $error("low ident not forwarded to high"); // [R7]
  a_pair_from_addr: assert property (rx_push |-> f_in[15:8] == act_addr[15:8] || f_in[15:8] == act_addr[7:0]) else $error("forward ident not from address bytes"); // [R8]
  a_deliv_src_match: assert property (!rep_on && rx_beat && rx_state == rrf_pkg::RX_HEAD && RX_SRC_ADDR != act_addr |=> !UART_OUT_VALID) else $error("foreign source delivered"); // [R9]
  a_chan_range: assert property (CFG_WE && CFG_CHAN > 8'h50 |=> CFG_REJECT && sv_chan == $past(sv_chan)) else $error("channel out of range taken"); // [R10]
  a_cfg_mode_only: assert property (CFG_WE && mode_q != 2'h2 |=> CFG_REJECT && sv_addr == $past(sv_addr)) else $error("write outside config mode"); // [R11]
  a_echo_blocked: assert property (echo_hit && rx_beat && rx_state == rrf_pkg::RX_HEAD |-> !rx_push) else $error("own echo forwarded"); // [R13]
  a_echo_window: assert property (TX_VALID && TX_READY && TX_LAST |=> echo_cnt == ECHO_N) else $error("echo guard not armed"); // [R13]
  c_forward: cover property (rx_push ##[1:40] TX_VALID && TX_READY);
  c_deliver: cover property (UART_OUT_VALID);
  c_fifo_full: cover property (f_lvl == 6'h20);
endmodule : rrf_repeater
`default_nettype wire

/* File: dv/rrf_radio_model.sv */
`timescale 1ns/100ps
`default_nettype none
module rrf_radio_model (
  // clock and stall control
  input  wire logic       clk,
  input  wire logic       stall,
  // transmit stream from the device
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_ident,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_last,
  output logic            tx_ready
);
  logic [16:0] got[$];
  initial tx_ready = 1'b0;
  // a stalled radio holds ready low so the fifo has to absorb the stream
  always @(posedge clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
      got.push_back({tx_last, tx_ident, tx_data});
    tx_ready <= !stall;
  end
endmodule : rrf_radio_model
`default_nettype wire

/* File: dv/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        CLK, SYS_RST, CE, CFG_WE, CFG_REJECT, AUX, REPEATER_ON, LOW_POWER_EN;
  logic [1:0]  MODE_SELECT_PINS;
  logic [15:0] CFG_ADDR, CFG_KEY, ACT_KEY, RX_SRC_ADDR;
  logic [7:0]  CFG_NETWORK_IDENT, CFG_CHAN, CFG_SERIAL, CFG_OPTION, ACT_CHAN, ACT_SERIAL;
  logic [7:0]  RX_NETWORK_IDENT, RX_DATA, TX_NETWORK_IDENT, TX_DATA, UART_IN_DATA, UART_OUT_DATA;
  logic        RX_VALID, RX_LAST, RX_READY, TX_VALID, TX_LAST, TX_READY;
  logic        UART_IN_VALID, UART_IN_LAST, UART_IN_READY, UART_OUT_VALID, stall, refused;
  logic [7:0]  out_byte;
  int          error_cnt, compares, cyc, rej_cnt, out_cnt;

  rrf_repeater DUT (.CLK(CLK), .SYS_RST(SYS_RST), .CE(CE), .MODE_SELECT_PINS(MODE_SELECT_PINS),
    .CFG_WE(CFG_WE), .CFG_ADDR(CFG_ADDR), .CFG_NETWORK_IDENT(CFG_NETWORK_IDENT), .CFG_CHAN(CFG_CHAN),
    .CFG_SERIAL(CFG_SERIAL), .CFG_OPTION(CFG_OPTION), .CFG_KEY(CFG_KEY), .CFG_REJECT(CFG_REJECT),
    .ACT_CHAN(ACT_CHAN), .ACT_SERIAL(ACT_SERIAL), .ACT_KEY(ACT_KEY), .AUX(AUX),
    .REPEATER_ON(REPEATER_ON), .LOW_POWER_EN(LOW_POWER_EN), .RX_VALID(RX_VALID),
    .RX_NETWORK_IDENT(RX_NETWORK_IDENT), .RX_SRC_ADDR(RX_SRC_ADDR), .RX_DATA(RX_DATA),
    .RX_LAST(RX_LAST), .RX_READY(RX_READY), .TX_VALID(TX_VALID), .TX_NETWORK_IDENT(TX_NETWORK_IDENT),
    .TX_DATA(TX_DATA), .TX_LAST(TX_LAST), .TX_READY(TX_READY), .UART_IN_VALID(UART_IN_VALID),
    .UART_IN_DATA(UART_IN_DATA), .UART_IN_LAST(UART_IN_LAST), .UART_IN_READY(UART_IN_READY),
    .UART_OUT_VALID(UART_OUT_VALID), .UART_OUT_DATA(UART_OUT_DATA));
  rrf_radio_model u_radio (.clk(CLK), .stall(stall), .tx_valid(TX_VALID), .tx_ident(TX_NETWORK_IDENT),
    .tx_data(TX_DATA), .tx_last(TX_LAST), .tx_ready(TX_READY));

  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end

  task automatic stop_test;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // pulses stand one cycle, so they are counted here rather than polled
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (CFG_REJECT === 1'b1) rej_cnt <= rej_cnt + 1;
    if (UART_OUT_VALID === 1'b1) out_cnt <= out_cnt + 1;
    if (UART_OUT_VALID === 1'b1) out_byte <= UART_OUT_DATA;
    if (RX_VALID === 1'b1 && RX_READY === 1'b0 && REPEATER_ON === 1'b1) refused <= 1'b1;
    if (cyc == 20000) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic mode_to(input logic [1:0] m, input logic rl);
    MODE_SELECT_PINS = m;
    repeat (10) @(negedge CLK);
    if (rl) check("aux in reload", AUX, 1'b0);
    while (AUX !== 1'b1) @(negedge CLK);
  endtask : mode_to

  task automatic cfg(input logic [15:0] a, input logic [7:0] id, ch, opt, input logic [15:0] k);
    CFG_ADDR = a;
    CFG_NETWORK_IDENT = id;
    CFG_CHAN = ch;
    CFG_OPTION = opt;
    CFG_KEY = k;
    CFG_WE = 1'b1;
    @(negedge CLK);
    CFG_WE = 1'b0;
    repeat (4) @(negedge CLK);
  endtask : cfg

  // ready is registered, so a high level seen here is taken at the next rising edge
  task automatic pkt(input logic [7:0] id, input logic [15:0] src, input logic [7:0] d, input int len);
    for (int i = 0; i < len; i++) begin
      RX_VALID = 1'b1;
      RX_NETWORK_IDENT = id;
      RX_SRC_ADDR = src;
      RX_DATA = d + 8'(i);
      RX_LAST = (i == len - 1);
      while (RX_READY !== 1'b1) @(negedge CLK);
      @(negedge CLK);
    end
    RX_VALID = 1'b0;
    RX_DATA = ~RX_DATA;
    // one idle edge, so a following call never re-raises valid in the same step
    @(negedge CLK);
  endtask : pkt

  initial begin
    {CFG_WE, RX_VALID, RX_LAST, UART_IN_VALID, UART_IN_LAST, stall, refused} = '0;
    {CFG_ADDR, CFG_KEY, RX_SRC_ADDR, CFG_NETWORK_IDENT, CFG_CHAN, CFG_OPTION} = '0;
    {RX_NETWORK_IDENT, RX_DATA, UART_IN_DATA} = '0;
    {error_cnt, compares, cyc, rej_cnt, out_cnt} = '0;
    CFG_SERIAL = 8'h62;
    CE = 1'b1;
    SYS_RST = 1'b1;
    MODE_SELECT_PINS = rrf_pkg::MODE_NORMAL;
    repeat (20) @(negedge CLK);
    SYS_RST = 1'b0;
    mode_to(rrf_pkg::MODE_NORMAL, 1'b1);
    check("def chan", ACT_CHAN, 8'h12);
    check("def serial", ACT_SERIAL, 8'h62);
    check("def key", ACT_KEY, 16'h0000);
    cfg(16'h0833, 8'h77, 8'h50, 8'h20, 16'hBEEF);
    check("rej outside cfg", rej_cnt, 1);
    mode_to(rrf_pkg::MODE_CFG, 1'b0);
    cfg(16'h0833, 8'h77, 8'h51, 8'h20, 16'hBEEF);
    check("rej chan 81", rej_cnt, 2);
    cfg(16'h0833, 8'h77, 8'h50, 8'h20, 16'hBEEF);
    check("chan 80 taken", rej_cnt, 2);
    check("idle in cfg", REPEATER_ON, 1'b0);
    mode_to(rrf_pkg::MODE_NORMAL, 1'b1);
    check("repeating", REPEATER_ON, 1'b1);
    check("act chan", ACT_CHAN, 8'h50);
    check("act key", ACT_KEY, 16'hBEEF);
    check("serial in off", UART_IN_READY, 1'b0);
    stall = 1'b1;
    fork
      begin
        repeat (300) @(negedge CLK);
        stall = 1'b0;
      end
    join_none
    pkt(8'h08, 16'h0000, 8'h00, 40);
    repeat (200) @(negedge CLK);
    check("fifo refused", refused, 1'b1);
    check("fwd count", u_radio.got.size(), 40);
    foreach (u_radio.got[i]) check("fwd beat", u_radio.got[i], {i == 39, 8'h33, 8'(i)});
    check("no serial out", out_cnt, 0);
    u_radio.got.delete();
    // outside the echo window, so the far network can answer
    repeat (1100) @(negedge CLK);
    pkt(8'h33, 16'h0000, 8'hA5, 1);
    // the answer has to leave the radio first, arming the echo guard
    repeat (10) @(negedge CLK);
    pkt(8'h08, 16'h0000, 8'h5A, 1);
    pkt(8'h77, 16'h0000, 8'hC3, 1);
    repeat (50) @(negedge CLK);
    check("back count", u_radio.got.size(), 1);
    check("back beat", u_radio.got[0], {1'b1, 8'h08, 8'hA5});
    mode_to(rrf_pkg::MODE_SLEEP, 1'b0);
    check("no low power", LOW_POWER_EN, 1'b0);
    mode_to(rrf_pkg::MODE_CFG, 1'b1);
    cfg(16'h1234, 8'h05, 8'h12, 8'h00, 16'h0000);
    mode_to(rrf_pkg::MODE_NORMAL, 1'b1);
    check("endpoint", REPEATER_ON, 1'b0);
    pkt(8'h05, 16'h1234, 8'h3C, 1);
    pkt(8'h05, 16'h1235, 8'h99, 1);
    repeat (20) @(negedge CLK);
    check("serial out count", out_cnt, 1);
    check("serial out byte", out_byte, 8'h3C);
    u_radio.got.delete();
    UART_IN_VALID = 1'b1;
    UART_IN_DATA = 8'h5A;
    UART_IN_LAST = 1'b1;
    while (UART_IN_READY !== 1'b1) @(negedge CLK);
    @(negedge CLK);
    UART_IN_VALID = 1'b0;
    repeat (20) @(negedge CLK);
    check("serial to air", u_radio.got[0], {1'b1, 8'h05, 8'h5A});
    mode_to(rrf_pkg::MODE_SLEEP, 1'b0);
    check("low power", LOW_POWER_EN, 1'b1);
    // clock enable low freezes the mode synchroniser, so sleep state must hold
    CE = 1'b0;
    MODE_SELECT_PINS = rrf_pkg::MODE_NORMAL;
    repeat (20) @(negedge CLK);
    check("frozen low power", LOW_POWER_EN, 1'b1);
    CE = 1'b1;
    mode_to(rrf_pkg::MODE_NORMAL, 1'b1);
    stop_test();
  end
endmodule : tb
`default_nettype wire
